/* File: bench/cell_env_model.sv */
// behavioural cell, charger and load feeding the comparator levels
`timescale 1ns/1ps

module cell_env_model (
  // scenario select and pull-up feedback
  input  wire logic       i_pullup_en,
  input  wire logic [3:0] i_mode,
  // comparator levels
  output logic            o_ovc_hi,
  output logic            o_ovc_rel,
  output logic            o_od_lo,
  output logic            o_od_rel,
  output logic            o_inh,
  output logic            o_dsg_oc,
  output logic            o_short,
  output logic            o_chg_oc,
  output logic            o_chg_min,
  output logic            o_neg07,
  output logic            o_in1v3,
  output logic            o_in1v,
  output logic            o_zchg
);
  // 8 dead cell with zero-volt charger
  // 0 normal, 1 overcharged cell, 2 flat cell no charger, 3 strong charger on recovered cell,
  // 4 heavy load, 5 shorted load, 6 charge overcurrent, 7 dead cell
  always_comb
  begin
    o_ovc_hi  = 1'b0;
    o_ovc_rel = 1'b0;
    o_od_lo   = 1'b0;
    o_od_rel  = 1'b1;
    o_inh     = 1'b0;
    o_dsg_oc  = 1'b0;
    o_short   = 1'b0;
    o_chg_oc  = 1'b0;
    o_chg_min = 1'b1;
    o_neg07   = 1'b0;
    o_in1v3   = 1'b0;
    o_in1v    = 1'b0;
    o_zchg    = 1'b0;
    case (i_mode)
      4'h1:
      begin
        o_ovc_hi  = 1'b1;
        o_ovc_rel = 1'b1;
      end
      4'h2:
      begin
        o_od_lo  = 1'b1;
        o_od_rel = 1'b0;
        // sense floats up to the cell only through the pull-up
        o_in1v3  = i_pullup_en;
      end
      4'h3:
      begin
        o_od_rel  = 1'b0;
        o_neg07   = 1'b1;
        o_chg_min = 1'b0;
      end
      4'h4:
      begin
        o_dsg_oc = 1'b1;
        o_in1v   = 1'b1;
      end
      4'h5:
      begin
        o_short  = 1'b1;
        o_dsg_oc = 1'b1;
        o_in1v   = 1'b1;
      end
      4'h6:
      begin
        o_chg_oc  = 1'b1;
        o_chg_min = 1'b0;
      end
      4'h7:
      begin
        o_inh    = 1'b1;
        o_od_lo  = 1'b1;
        o_od_rel = 1'b0;
      end
      4'h8:
      begin
        o_od_lo  = 1'b1;
        o_od_rel = 1'b0;
        o_zchg   = 1'b1;
      end
      default:
      begin
        o_in1v = 1'b0;
      end
    endcase
  end
endmodule

/* File: bench/test_cell_prot_fsm.sv */
// self-checking bench for the cell protection controller
`timescale 1ns/1ps

module test_cell_prot_fsm
  import cell_prot_pkg::*;
();
  localparam int DIV = 5;
  localparam int OVC = 2500;
  localparam int UVD = 960;
  localparam int DOC = 160;
  localparam int COC = 80;
  localparam int REC = 10;

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] mode = 4'h0;
  logic       ce = 1'b1;
  logic       zchg;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         n;
  logic ovc_hi, ovc_rel, od_lo, od_rel, inh, dsg_oc, shrt, chg_oc, chg_min, neg07, in1v3, in1v;
  logic chg, dsg, tie, pull, sink, pdn;
  logic [2:0] st;

  always #10 clk = ~clk;

  cell_env_model env (.i_pullup_en(pull), .i_mode(mode), .o_ovc_hi(ovc_hi), .o_ovc_rel(ovc_rel),
    .o_od_lo(od_lo), .o_od_rel(od_rel), .o_inh(inh), .o_dsg_oc(dsg_oc), .o_short(shrt), .o_chg_oc(chg_oc),
    .o_chg_min(chg_min), .o_neg07(neg07), .o_in1v3(in1v3), .o_in1v(in1v), .o_zchg(zchg));

  cell_prot_fsm #(.OVC_SEL(2'h0), .DIV(DIV)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_cell_above_overcharge_threshold(ovc_hi), .i_cell_above_overcharge_release_level(ovc_rel),
    .i_cell_below_overdischarge_threshold(od_lo), .i_cell_above_overdischarge_release_level(od_rel),
    .i_cell_below_zero_volt_inhibit_level(inh), .i_sense_above_discharge_overcurrent_threshold(dsg_oc),
    .i_sense_above_short_circuit_threshold(shrt), .i_sense_below_charge_overcurrent_threshold(chg_oc),
    .i_sense_above_charge_overcurrent_min(chg_min), .i_sense_below_minus_0v7(neg07),
    .i_sense_within_1v3_of_cell(in1v3), .i_sense_within_1v_of_cell(in1v),
    .i_charger_at_zero_volt_charge_start_level(zchg), .o_charge_gate_out(chg), .o_discharge_gate_out(dsg),
    .o_charge_gate_tie_cell(tie), .o_sense_pullup_en(pull), .o_sense_sink_en(sink), .o_power_down(pdn),
    .o_state(st));

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic check_min(input int got, input int lim, input string what);
    samples_checked++;
    if (got < lim)
    begin
      fail_count++;
      $display("ERROR %0t %s too early", $time, what);
    end
  endtask

  // polls once a cycle, cycles spent returned in cyc
  task automatic wait_state(input prot_state_t exp, input int max_cyc, output int cyc);
    cyc = 0;
    while (st !== exp && cyc < max_cyc)
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
    samples_checked++;
    if (st !== exp)
    begin
      fail_count++;
      $display("ERROR %0t state %0d not reached", $time, exp);
      end_sim();
    end
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(posedge clk);
    #1;
    mode = m;
  endtask

  task automatic t_reset();
    check_bit(chg, 1'b1, "charge gate after reset");
    check_bit(dsg, 1'b1, "discharge gate after reset");
    check_bit(pull, 1'b1, "pull-up after reset");
    check_bit(sink, 1'b0, "sink after reset");
    check_bit(tie, 1'b0, "tie after reset");
    check_bit(pdn, 1'b0, "power down after reset");
  endtask

  task automatic t_overcharge();
    set_mode(4'h1);
    wait_state(ST_OVERCHARGE, OVC * DIV + 40, n);
    check_min(n, (OVC - 1) * DIV, "overcharge trip");
    check_bit(chg, 1'b0, "charge gate in overcharge");
    check_bit(dsg, 1'b1, "discharge gate in overcharge");
    // charger still attached, cell already below release level
    set_mode(4'h6);
    repeat (REC * DIV + 20) @(posedge clk);
    #1;
    check_bit(st == ST_OVERCHARGE, 1'b1, "charger kept overcharge");
    set_mode(4'h0);
    wait_state(ST_NORMAL, REC * DIV + 40, n);
    check_min(n, (REC - 1) * DIV, "overcharge release");
    check_bit(chg, 1'b1, "charge gate released");
  endtask

  task automatic t_overdischarge();
    set_mode(4'h2);
    wait_state(ST_OVERDISCHARGE, UVD * DIV + 40, n);
    check_min(n, (UVD - 1) * DIV, "overdischarge trip");
    check_bit(dsg, 1'b0, "discharge gate low");
    check_bit(pull, 1'b1, "pull-up on");
    check_bit(sink, 1'b0, "sink off");
    wait_state(ST_POWERDOWN, 40, n);
    check_bit(pdn, 1'b1, "power down flag");
    set_mode(4'h3);
    wait_state(ST_NORMAL, REC * DIV + 80, n);
    check_bit(dsg, 1'b1, "discharge gate back on");
    // second pass with a weak charger, release at release level
    set_mode(4'h2);
    wait_state(ST_POWERDOWN, UVD * DIV + 80, n);
    set_mode(4'h0);
    wait_state(ST_NORMAL, REC * DIV + 80, n);
    check_bit(dsg, 1'b1, "weak charger release");
  endtask

  task automatic t_dsg_oc();
    set_mode(4'h4);
    wait_state(ST_DSG_OVERCURRENT, DOC * DIV + 40, n);
    check_min(n, (DOC - 1) * DIV, "overcurrent trip");
    check_bit(dsg, 1'b0, "discharge gate in overcurrent");
    check_bit(sink, 1'b1, "sink in overcurrent");
    check_bit(pull, 1'b0, "pull-up in overcurrent");
    set_mode(4'h0);
    wait_state(ST_NORMAL, REC * DIV + 40, n);
    check_bit(dsg, 1'b1, "discharge gate restored");
  endtask

  task automatic t_short();
    repeat (3)
    begin
      set_mode(4'h5);
      repeat (7) @(posedge clk);
      set_mode(4'h0);
      repeat (20) @(posedge clk);
    end
    #1;
    check_bit(dsg, 1'b1, "brief short tripped");
    set_mode(4'h5);
    wait_state(ST_DSG_OVERCURRENT, 5 * DIV + 10, n);
    check_min(n, 2 * DIV, "short trip");
    check_bit(dsg, 1'b0, "discharge gate after short");
    set_mode(4'h0);
    wait_state(ST_NORMAL, REC * DIV + 40, n);
  endtask

  task automatic t_chg_oc();
    set_mode(4'h6);
    wait_state(ST_CHG_OVERCURRENT, COC * DIV + 40, n);
    check_min(n, (COC - 1) * DIV, "charge overcurrent trip");
    check_bit(chg, 1'b0, "charge gate in overcurrent");
    check_bit(pull, 1'b0, "pull-up off");
    check_bit(sink, 1'b0, "sink off");
    set_mode(4'h0);
    wait_state(ST_NORMAL, REC * DIV + 40, n);
    check_bit(chg, 1'b1, "charge gate restored");
  endtask

  task automatic t_zero_volt();
    set_mode(4'h8);
    wait_state(ST_ZERO_VOLT, 10, n);
    check_bit(tie, 1'b1, "gate tied to cell");
    check_bit(chg, 1'b1, "charge gate in zero volt");
    check_bit(dsg, 1'b0, "discharge gate in zero volt");
    set_mode(4'h0);
    wait_state(ST_NORMAL, 10, n);
    check_bit(tie, 1'b0, "tie released");
  endtask

  task automatic t_inhibit();
    // clock enable low freezes the synchronisers and the gates
    @(posedge clk);
    #1;
    ce = 1'b0;
    mode = 4'h7;
    repeat (10) @(posedge clk);
    #1;
    check_bit(chg, 1'b1, "charge gate frozen");
    ce = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check_bit(chg, 1'b0, "charge gate under inhibit");
    set_mode(4'h0);
    repeat (REC * DIV + 20) @(posedge clk);
    #1;
    check_bit(chg, 1'b1, "charge gate after inhibit");
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_overcharge();
    t_overdischarge();
    t_dsg_oc();
    t_short();
    t_chg_oc();
    t_zero_volt();
    t_inhibit();
    end_sim();
  end
endmodule

/* File: design/cell_prot_consts.svh */
// timing constants and selector encodings for the cell protection controller
`ifndef CELL_PROT_CONSTS_SVH
`define CELL_PROT_CONSTS_SVH

`define CLK_HZ            50000000
`define TICK_HZ           10000
`define TICK_DIV          (`CLK_HZ / `TICK_HZ)

// delays in microseconds, converted to 10 kHz ticks (100 us per tick)
`define TICK_US           100
`define OVC_DLY_US_0      250000
`define OVC_DLY_US_1      1000000
`define OVC_DLY_US_2      1250000
`define OVC_DLY_US_3      4500000
`define UVD_DLY_US        96000
`define OCD_DLY_US        16000
`define OCC_DLY_US        8000
`define SHORT_DLY_US      250
`define RECOVER_DLY_US    1000

`define OVC_SEL_RST       2'h0

`endif

/* File: design/cell_prot_fsm.sv */
// fault-state controller for a single-cell lithium protector
`timescale 1ns/1ps
`include "cell_prot_consts.svh"

// How it works
// - normal mode: both gate outputs on
// - sustained overcharge drops charge gate
// - release overcharge below release level, sense normal
// - discharging sense: release below overcharge threshold
// - charger present keeps overcharge latched
// - overcharge blocks discharge overcurrent and short detection
// - sustained low cell drops discharge gate
// - over-discharge: pull-up on, sink off, power-down
// - charger lifts sense difference, leaves power-down
// - deep charger: release at over-discharge threshold
// - weak charger: release at release level
// - discharge overcurrent: gate off, sink on
// - sense near cell-minus-1V returns normal
// - sustained charge overcurrent drops charge gate
// - sense back above threshold returns normal
// - no charge overcurrent in over-discharge
// - charge overcurrent: pull-up and sink off
// - zero-volt charge ties gate, normal later
// - expired charge overcurrent beats zero-volt entry
// - below inhibit level charge gate held low
// - timers run from 10 kHz tick
// - short circuit trips after short delay
// - recovery timer before gate returns on, except zero-volt exit and inhibit release
// - short delay fixed at 300 us (250 us rounded up to 3 ticks)
// - overcharge delay one of four values

module cell_prot_fsm
  import cell_prot_pkg::*;
#(
  parameter logic [1:0] OVC_SEL = `OVC_SEL_RST,
  parameter int         TW      = 16,
  parameter int         DIV     = `TICK_DIV
) (
  // clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // comparator results, asynchronous
  input  wire logic i_cell_above_overcharge_threshold,
  input  wire logic i_cell_above_overcharge_release_level,
  input  wire logic i_cell_below_overdischarge_threshold,
  input  wire logic i_cell_above_overdischarge_release_level,
  input  wire logic i_cell_below_zero_volt_inhibit_level,
  input  wire logic i_sense_above_discharge_overcurrent_threshold,
  input  wire logic i_sense_above_short_circuit_threshold,
  input  wire logic i_sense_below_charge_overcurrent_threshold,
  input  wire logic i_sense_above_charge_overcurrent_min,
  input  wire logic i_sense_below_minus_0v7,
  input  wire logic i_sense_within_1v3_of_cell,
  input  wire logic i_sense_within_1v_of_cell,
  input  wire logic i_charger_at_zero_volt_charge_start_level,
  // gate and sense controls
  output logic      o_charge_gate_out,
  output logic      o_discharge_gate_out,
  output logic      o_charge_gate_tie_cell,
  output logic      o_sense_pullup_en,
  output logic      o_sense_sink_en,
  output logic      o_power_down,
  output logic [2:0] o_state
);

  localparam int DIV_W = $clog2(DIV);
  localparam logic [TW-1:0] OVC_LIM_0 = TW'(`OVC_DLY_US_0 / `TICK_US);
  localparam logic [TW-1:0] OVC_LIM_1 = TW'(`OVC_DLY_US_1 / `TICK_US);
  localparam logic [TW-1:0] OVC_LIM_2 = TW'(`OVC_DLY_US_2 / `TICK_US);
  localparam logic [TW-1:0] OVC_LIM_3 = TW'(`OVC_DLY_US_3 / `TICK_US);
  localparam logic [TW-1:0] OVC_LIM   = (OVC_SEL == 2'h0) ? OVC_LIM_0 :
                                        (OVC_SEL == 2'h1) ? OVC_LIM_1 :
                                        (OVC_SEL == 2'h2) ? OVC_LIM_2 : OVC_LIM_3;
  localparam logic [TW-1:0] UVD_LIM   = TW'(`UVD_DLY_US / `TICK_US);
  localparam logic [TW-1:0] OCD_LIM   = TW'(`OCD_DLY_US / `TICK_US);
  localparam logic [TW-1:0] OCC_LIM   = TW'(`OCC_DLY_US / `TICK_US);
  localparam logic [TW-1:0] SHORT_LIM = TW'((`SHORT_DLY_US + `TICK_US - 1) / `TICK_US);
  localparam logic [TW-1:0] REC_LIM   = TW'(`RECOVER_DLY_US / `TICK_US);

  localparam int NIN = 13;
  localparam int NT  = 6;

  typedef struct packed {
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [DIV_W-1:0] div;
    logic             tick;
    prot_state_t      st;
    logic             chg;
    logic             dsg;
    logic             tie;
    logic             pull;
    logic             sink;
    logic             pdn;
  } fsm_t;

  fsm_t s_q;
  fsm_t s_d;

  logic [NIN-1:0] raw;
  logic ov;
  logic ov_rel;
  logic uv;
  logic uv_rel;
  logic inh;
  logic ocd;
  logic scc;
  logic occ;
  logic occ_min;
  logic neg07;
  logic w13;
  logic w1;
  logic zchg;

  assign raw = {i_cell_above_overcharge_threshold, i_cell_above_overcharge_release_level,
                i_cell_below_overdischarge_threshold, i_cell_above_overdischarge_release_level,
                i_cell_below_zero_volt_inhibit_level, i_sense_above_discharge_overcurrent_threshold,
                i_sense_above_short_circuit_threshold, i_sense_below_charge_overcurrent_threshold,
                i_sense_above_charge_overcurrent_min, i_sense_below_minus_0v7,
                i_sense_within_1v3_of_cell, i_sense_within_1v_of_cell,
                i_charger_at_zero_volt_charge_start_level};
  assign {ov, ov_rel, uv, uv_rel, inh, ocd, scc, occ, occ_min, neg07, w13, w1, zchg} = s_q.sync2;

  // detection and recovery timers
  logic [NT-1:0]    t_cond;
  logic [NT-1:0]    t_exp;
  logic [NT*TW-1:0] t_lim;
  logic             rec_cond;

  localparam int T_OV  = 0;
  localparam int T_UV  = 1;
  localparam int T_OCD = 2;
  localparam int T_SC  = 3;
  localparam int T_OCC = 4;
  localparam int T_REC = 5;

  assign t_cond[T_OV]  = (s_q.st == ST_NORMAL) && ov;
  assign t_cond[T_UV]  = (s_q.st == ST_NORMAL || s_q.st == ST_OVERCHARGE) && uv;
  assign t_cond[T_OCD] = (s_q.st == ST_NORMAL) && ocd && !ov;
  assign t_cond[T_SC]  = (s_q.st == ST_NORMAL) && scc && !ov;
  assign t_cond[T_OCC] = (s_q.st == ST_NORMAL) && occ && !uv;
  assign t_cond[T_REC] = rec_cond;
  assign t_lim = {REC_LIM, OCC_LIM, SHORT_LIM, OCD_LIM, UVD_LIM, OVC_LIM};

  genvar g;
  generate
    for (g = 0; g < NT; g++)
    begin : g_tmr
      fault_timer #(.W(TW)) u_tmr (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_tick    (s_q.tick),
        .i_cond    (t_cond[g]),
        .i_limit   (t_lim[g*TW +: TW]),
        .o_expired (t_exp[g])
      );
    end
  endgenerate

  // release condition per fault state
  always_comb
  begin
    rec_cond = 1'b0;
    case (s_q.st)
      ST_OVERCHARGE:
      begin
        if (ocd)
          rec_cond = !ov;
        else if (occ_min && !zchg)
          rec_cond = !ov_rel;
        else
          rec_cond = 1'b0;
      end
      ST_OVERDISCHARGE, ST_POWERDOWN:
      begin
        if (neg07)
          rec_cond = !uv;
        else
          rec_cond = uv_rel && !w13;
      end
      ST_DSG_OVERCURRENT: rec_cond = !w1;
      ST_CHG_OVERCURRENT: rec_cond = !occ;
      default:            rec_cond = 1'b0;
    endcase
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = raw;
    s_d.sync2 = s_q.sync1;
    s_d.tick  = 1'b0;
    if (s_q.div == DIV_W'(DIV - 1))
    begin
      s_d.div  = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.div = s_q.div + DIV_W'(1);
    end
    case (s_q.st)
      ST_NORMAL:
      begin
        if (t_exp[T_UV])
          s_d.st = ST_OVERDISCHARGE;
        else if (t_exp[T_SC] || t_exp[T_OCD])
          s_d.st = ST_DSG_OVERCURRENT;
        else if (t_exp[T_OV])
          s_d.st = ST_OVERCHARGE;
        else if (t_exp[T_OCC])
          s_d.st = ST_CHG_OVERCURRENT;
        else if (uv && zchg)
          s_d.st = ST_ZERO_VOLT;
      end
      ST_OVERCHARGE:
      begin
        if (t_exp[T_UV])
          s_d.st = ST_OVERDISCHARGE;
        else if (t_exp[T_REC])
          s_d.st = ST_NORMAL;
      end
      ST_OVERDISCHARGE:
      begin
        if (t_exp[T_REC])
          s_d.st = ST_NORMAL;
        else if (w13)
          s_d.st = ST_POWERDOWN;
      end
      ST_POWERDOWN:
      begin
        if (t_exp[T_REC])
          s_d.st = ST_NORMAL;
        else if (!w13)
          s_d.st = ST_OVERDISCHARGE;
      end
      ST_DSG_OVERCURRENT, ST_CHG_OVERCURRENT:
      begin
        if (t_exp[T_REC])
          s_d.st = ST_NORMAL;
      end
      ST_ZERO_VOLT:
      begin
        if (uv_rel || !zchg)
          s_d.st = ST_NORMAL;
      end
      default: s_d.st = ST_NORMAL;
    endcase
    // outputs follow the next state
    s_d.chg  = 1'b1;
    s_d.dsg  = 1'b1;
    s_d.tie  = 1'b0;
    s_d.pull = 1'b1;
    s_d.sink = 1'b0;
    s_d.pdn  = 1'b0;
    case (s_d.st)
      ST_OVERCHARGE:      s_d.chg = 1'b0;
      ST_OVERDISCHARGE:
      begin
        s_d.dsg  = 1'b0;
        s_d.pull = 1'b1;
        s_d.sink = 1'b0;
      end
      ST_POWERDOWN:
      begin
        s_d.dsg = 1'b0;
        s_d.pdn = 1'b1;
      end
      ST_DSG_OVERCURRENT:
      begin
        s_d.dsg  = 1'b0;
        s_d.sink = 1'b1;
        s_d.pull = 1'b0;
      end
      ST_CHG_OVERCURRENT:
      begin
        s_d.chg  = 1'b0;
        s_d.pull = 1'b0;
        s_d.sink = 1'b0;
      end
      ST_ZERO_VOLT:
      begin
        s_d.dsg = 1'b0;
        s_d.tie = 1'b1;
      end
      default: s_d.chg = 1'b1;
    endcase
    if (inh)
    begin
      s_d.chg = 1'b0;
      s_d.tie = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q      <= '0;
      s_q.st   <= ST_NORMAL;
      s_q.chg  <= 1'b1;
      s_q.dsg  <= 1'b1;
      s_q.pull <= 1'b1;
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end

  assign o_charge_gate_out    = s_q.chg;
  assign o_discharge_gate_out = s_q.dsg;
  assign o_charge_gate_tie_cell = s_q.tie;
  assign o_sense_pullup_en    = s_q.pull;
  assign o_sense_sink_en      = s_q.sink;
  assign o_power_down         = s_q.pdn;
  assign o_state              = s_q.st;

  a_inhibit_chg : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && inh) |=> !o_charge_gate_out)
    else $error("charge gate on below inhibit level");
  a_normal_gates : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && s_d.st == ST_NORMAL && !inh) |=> (o_charge_gate_out && o_discharge_gate_out))
    else $error("gate off in normal mode");
  a_ovc_gate : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_q.st == ST_OVERCHARGE) |-> !o_charge_gate_out)
    else $error("charge gate on in overcharge");
  a_ocd_sink : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_q.st == ST_DSG_OVERCURRENT) |-> (o_sense_sink_en && !o_sense_pullup_en && !o_discharge_gate_out))
    else $error("discharge overcurrent controls wrong");
  a_occ_float : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_q.st == ST_CHG_OVERCURRENT) |-> (!o_sense_sink_en && !o_sense_pullup_en))
    else $error("charge overcurrent sense not floating");
  a_uv_pullup : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_q.st == ST_OVERDISCHARGE) |-> (o_sense_pullup_en && !o_sense_sink_en && !o_discharge_gate_out))
    else $error("over-discharge sense controls wrong");
  a_short_trip : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && s_q.st == ST_NORMAL && t_exp[T_SC] && !t_exp[T_UV]) |=> (s_q.st == ST_DSG_OVERCURRENT))
    else $error("short circuit did not trip");
  a_tick_period : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_q.tick && i_ce) |=> !s_q.tick)
    else $error("tick longer than one cycle");

endmodule

/* File: design/cell_prot_pkg.sv */
// types for the cell protection controller
package cell_prot_pkg;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_OVERCHARGE,
    ST_OVERDISCHARGE,
    ST_POWERDOWN,
    ST_DSG_OVERCURRENT,
    ST_CHG_OVERCURRENT,
    ST_ZERO_VOLT
  } prot_state_t;

endpackage

/* File: design/fault_timer.sv */
// continuous-condition tick counter used for detection and recovery delays
`timescale 1ns/1ps

module fault_timer #(
  parameter int W = 16
) (
  // clock, reset and enable
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  // control
  input  wire logic         i_tick,
  input  wire logic         i_cond,
  input  wire logic [W-1:0] i_limit,
  // status
  output logic              o_expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } tmr_t;

  tmr_t s_q;
  tmr_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!i_cond)
    begin
      s_d.cnt = '0;
      s_d.exp = 1'b0;
    end
    else if (i_tick && !s_q.exp)
    begin
      if (s_q.cnt + W'(1) >= i_limit)
      begin
        s_d.exp = 1'b1;
      end
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else if (i_ce)
    begin
      s_q <= s_d;
    end
  end

  assign o_expired = s_q.exp;

  a_restart_clear : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && !i_cond) |=> !o_expired)
    else $error("timer expired without its condition");

endmodule
